// ==== shared/pps_pkg.sv ====
// constants, states and status layout of the push-pull drive sequencer
package pps_pkg;

   // ----------------------------------------------------------------
   // clock and oscillator
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned CLK_MHZ = 125;
   // internal oscillator runs at twice the switching rate
   localparam int unsigned OSC_HZ = 880_000;
   localparam int unsigned STARTUP_OSC_HZ = 600_000;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] OSC_HALF_CYC = CNT_W'(CLK_HZ / OSC_HZ);
   localparam logic [CNT_W-1:0] STARTUP_HALF_CYC = CNT_W'(CLK_HZ / STARTUP_OSC_HZ);
   localparam int SSC_W = 4;
   localparam logic [SSC_W-1:0] SSC_MAX = 4'hF;
   localparam logic [SSC_W-1:0] SSC_MIN = 4'h0;

   // ----------------------------------------------------------------
   // gate drive timing
   // ----------------------------------------------------------------
   localparam int unsigned DEAD_NS = 90;
   localparam int DEAD_W = 4;
   // least time, rounded up
   localparam logic [DEAD_W-1:0] DEAD_CYC = DEAD_W'((DEAD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] CL_ON_CYC = OSC_HALF_CYC >> 1;

   // ----------------------------------------------------------------
   // protection and soft-start timing
   // ----------------------------------------------------------------
   localparam int TIMER_W = 24;
   localparam int unsigned OC_TIMEOUT_MS = 10;
   localparam int unsigned OC_TIMEOUT_CYC_DEF = OC_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned DEAD_MODE_MS = 10;
   localparam int unsigned DEAD_MODE_CYC_DEF = DEAD_MODE_MS * (CLK_HZ / 1000);
   localparam int unsigned SS_TIME_US = 5000;
   localparam int unsigned SS_TOTAL_CYC_DEF = SS_TIME_US * CLK_MHZ;
   localparam int LEVEL_W = 8;
   localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 8'h00;
   localparam logic [LEVEL_W-1:0] LEVEL_MAX = 8'hFF;

   // ----------------------------------------------------------------
   // synchronised pin inputs
   // ----------------------------------------------------------------
   localparam int PIN_W = 5;
   localparam int PIN_EN = 0;
   localparam int PIN_OC = 1;
   localparam int PIN_START = 2;
   localparam int PIN_NOM = 3;
   localparam int PIN_UV = 4;

   // ----------------------------------------------------------------
   // sequencing states, gray along off-soft-run-limit-dead
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_SOFT = 3'h1,
      ST_RUN = 3'h3,
      ST_CLIM = 3'h2,
      ST_DEAD = 3'h6
   } pps_state_e;

   typedef struct packed {
      pps_state_e state;
      logic osc_run;
      logic osc_full;
      logic [LEVEL_W-1:0] drive_level;
   } pps_status_s;

endpackage

// ==== rtl/pps_osc.sv ====
// internal oscillator with start-up rate and spread spectrum modulation
`timescale 1ns/100ps
`default_nettype none

module pps_osc
(
   input wire logic clock_i, // system clock
   input wire logic rst_i, // synchronous reset, active high
   input wire logic run_i, // oscillator allowed to run
   input wire logic full_i, // supply near nominal, full operation
   output logic tick_o // one pulse per oscillator period, half a switching cycle
);

   logic [pps_pkg::CNT_W-1:0] cnt_r;
   logic [pps_pkg::CNT_W-1:0] period;
   logic [pps_pkg::SSC_W-1:0] ssc_off_r;
   logic ssc_up_r;
   logic pair_r;

   // ----------------------------------------------------------------
   // period select
   // ----------------------------------------------------------------
   // slow start-up rate
   always_comb
   begin
      if (full_i)
      begin
         period = pps_pkg::OSC_HALF_CYC + {{(pps_pkg::CNT_W-pps_pkg::SSC_W){1'b0}}, ssc_off_r};
      end
      else
      begin
         period = pps_pkg::STARTUP_HALF_CYC;
      end
   end

   // ----------------------------------------------------------------
   // half period counter
   // ----------------------------------------------------------------
   // held until supply up
   always_ff @(posedge clock_i)
   begin
      if (rst_i || !run_i)
      begin
         cnt_r <= '0;
         tick_o <= 1'b0;
      end
      // >= so a shorter period taken mid-count still ends this half
      else if (cnt_r >= period - 8'h01)
      begin
         cnt_r <= '0;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 8'h01;
         tick_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // spread spectrum triangle
   // ----------------------------------------------------------------
   // triangle sweep of period
   // step only between cycles
   // both halves of one switching cycle share a period, so on-times match
   always_ff @(posedge clock_i)
   begin
      if (rst_i || !run_i)
      begin
         ssc_off_r <= pps_pkg::SSC_MIN;
         ssc_up_r <= 1'b1;
         pair_r <= 1'b0;
      end
      else if (tick_o)
      begin
         pair_r <= ~pair_r;
         if (pair_r)
         begin
            if (ssc_up_r)
            begin
               if (ssc_off_r == pps_pkg::SSC_MAX)
               begin
                  ssc_up_r <= 1'b0;
                  ssc_off_r <= ssc_off_r - 4'h1;
               end
               else
               begin
                  ssc_off_r <= ssc_off_r + 4'h1;
               end
            end
            else
            begin
               if (ssc_off_r == pps_pkg::SSC_MIN)
               begin
                  ssc_up_r <= 1'b1;
                  ssc_off_r <= ssc_off_r + 4'h1;
               end
               else
               begin
                  ssc_off_r <= ssc_off_r - 4'h1;
               end
            end
         end
      end
   end

endmodule // pps_osc

`default_nettype wire

// ==== rtl/pps_drive_sequencer.sv ====
// push-pull gate drive sequencer: start-up, soft-start, protection, phases
`timescale 1ns/100ps
`default_nettype none

module pps_drive_sequencer #(
   parameter int unsigned OC_TIMEOUT_CYC = pps_pkg::OC_TIMEOUT_CYC_DEF,
   parameter int unsigned DEAD_MODE_CYC = pps_pkg::DEAD_MODE_CYC_DEF,
   parameter int unsigned SS_TOTAL_CYC = pps_pkg::SS_TOTAL_CYC_DEF
)
(
   input wire logic clock_i, // system clock, 125 MHz
   input wire logic rst_i, // synchronous reset, active high
   input wire logic enable_i, // enable pin, pulled low outside
   input wire logic overcurrent_i, // switch current above detect threshold
   input wire logic supply_start_i, // supply above start-up level
   input wire logic supply_nominal_i, // supply within nominal tolerance
   input wire logic supply_uv_i, // supply below undervoltage limit
   output logic drain_out_a_o, // open-drain level when driven, low
   output logic drain_out_a_oe_o, // switch a on
   output logic drain_out_b_o, // open-drain level when driven, low
   output logic drain_out_b_oe_o, // switch b on
   output logic phase_a_o, // divided phase a
   output logic phase_b_o, // divided phase b
   output logic [pps_pkg::LEVEL_W-1:0] drive_level_o, // gate drive amplitude
   output pps_pkg::pps_status_s status_o // sequencer status
);

   localparam int TW = pps_pkg::TIMER_W;
   localparam int unsigned SS_STEP_RAW = SS_TOTAL_CYC / (1 << pps_pkg::LEVEL_W);
   localparam int unsigned SS_STEP_CYC = (SS_STEP_RAW > 0) ? SS_STEP_RAW : 1;
   localparam logic [TW-1:0] OC_LAST = TW'(OC_TIMEOUT_CYC - 1);
   localparam logic [TW-1:0] DEAD_LAST = TW'(DEAD_MODE_CYC - 1);
   localparam logic [TW-1:0] SS_LAST = TW'(SS_STEP_CYC - 1);

   logic [pps_pkg::PIN_W-1:0] sync1_r;
   logic [pps_pkg::PIN_W-1:0] sync2_r;
   logic [pps_pkg::PIN_W-1:0] sync3_r;
   logic [pps_pkg::PIN_W-1:0] pin_r;
   logic active;
   logic oc;
   logic osc_run;
   logic osc_full;
   logic tick;
   pps_pkg::pps_state_e state_r;
   pps_pkg::pps_state_e state_nxt;
   logic [TW-1:0] timer_r;
   logic [TW-1:0] ss_cnt_r;
   logic [pps_pkg::LEVEL_W-1:0] level_r;
   logic div_r;
   logic [pps_pkg::DEAD_W-1:0] dead_cnt_r;
   logic [pps_pkg::CNT_W-1:0] on_cnt_r;
   logic gate_en;

   function automatic logic drive_state(input pps_pkg::pps_state_e st);
      drive_state = (st == pps_pkg::ST_SOFT) || (st == pps_pkg::ST_RUN) ||
                    (st == pps_pkg::ST_CLIM);
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // a bit is taken only when the second and third stages agree
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
         pin_r <= '0;
      end
      else
      begin
         sync1_r <= {supply_uv_i, supply_nominal_i, supply_start_i, overcurrent_i, enable_i};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         pin_r <= (sync2_r & sync3_r) | (pin_r & (sync2_r ^ sync3_r));
      end
   end

   // supply and enable gate all drive
   assign active = pin_r[pps_pkg::PIN_EN] && pin_r[pps_pkg::PIN_START] &&
                   !pin_r[pps_pkg::PIN_UV];
   assign oc = pin_r[pps_pkg::PIN_OC];
   assign osc_run = active;
   assign osc_full = pin_r[pps_pkg::PIN_NOM];

   // ----------------------------------------------------------------
   // oscillator
   // ----------------------------------------------------------------
   pps_osc u_osc
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .run_i(osc_run),
      .full_i(osc_full),
      .tick_o(tick)
   );

   // ----------------------------------------------------------------
   // protection and soft-start sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         pps_pkg::ST_OFF:
         begin
            state_nxt = pps_pkg::ST_SOFT;
         end
         pps_pkg::ST_SOFT:
         begin
            if (level_r == pps_pkg::LEVEL_MAX)
            begin
               state_nxt = pps_pkg::ST_RUN;
            end
         end
         pps_pkg::ST_RUN:
         begin
            if (oc)
            begin
               state_nxt = pps_pkg::ST_CLIM;
            end
         end
         pps_pkg::ST_CLIM:
         begin
            if (!oc)
            begin
               state_nxt = pps_pkg::ST_RUN;
            end
            else if (timer_r == OC_LAST)
            begin
               state_nxt = pps_pkg::ST_DEAD;
            end
         end
         pps_pkg::ST_DEAD:
         begin
            if (timer_r == DEAD_LAST)
            begin
               state_nxt = pps_pkg::ST_SOFT;
            end
         end
         default:
         begin
            state_nxt = pps_pkg::ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i || !active)
      begin
         state_r <= pps_pkg::ST_OFF;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // timeout restarts on clear
   // one timer serves both the overcurrent wait and the dead interval
   always_ff @(posedge clock_i)
   begin
      if (rst_i || !active || (state_nxt != state_r) ||
          ((state_r == pps_pkg::ST_CLIM) && !oc))
      begin
         timer_r <= '0;
      end
      else if ((state_r == pps_pkg::ST_CLIM) || (state_r == pps_pkg::ST_DEAD))
      begin
         timer_r <= timer_r + 24'h000001;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i || !active)
      begin
         level_r <= pps_pkg::LEVEL_ZERO;
         ss_cnt_r <= '0;
      end
      else if ((state_r == pps_pkg::ST_OFF) || (state_r == pps_pkg::ST_DEAD))
      begin
         level_r <= pps_pkg::LEVEL_ZERO;
         ss_cnt_r <= '0;
      end
      else if (state_r == pps_pkg::ST_SOFT)
      begin
         if (ss_cnt_r == SS_LAST)
         begin
            ss_cnt_r <= '0;
            if (level_r != pps_pkg::LEVEL_MAX)
            begin
               level_r <= level_r + 8'h01;
            end
         end
         else
         begin
            ss_cnt_r <= ss_cnt_r + 24'h000001;
         end
      end
      else
      begin
         level_r <= pps_pkg::LEVEL_MAX;
         ss_cnt_r <= '0;
      end
   end

   // ----------------------------------------------------------------
   // divider and break-before-make
   // ----------------------------------------------------------------
   // divide oscillator by two
   always_ff @(posedge clock_i)
   begin
      if (rst_i || !osc_run)
      begin
         div_r <= 1'b0;
      end
      else if (tick)
      begin
         div_r <= ~div_r;
      end
   end

   // both low before any rise
   // reset loads the count too, so the very first pulse also waits
   always_ff @(posedge clock_i)
   begin
      if (rst_i || !osc_run || tick)
      begin
         dead_cnt_r <= pps_pkg::DEAD_CYC;
      end
      else if (dead_cnt_r != '0)
      begin
         dead_cnt_r <= dead_cnt_r - 4'h1;
      end
   end

   // on-time of this phase; parked past the cap once cut, so no re-rise without a dead gap
   always_ff @(posedge clock_i)
   begin
      if (rst_i || !osc_run || tick)
      begin
         on_cnt_r <= '0;
      end
      else if ((state_r == pps_pkg::ST_CLIM) && (on_cnt_r == pps_pkg::CL_ON_CYC))
      begin
         on_cnt_r <= pps_pkg::CL_ON_CYC + 8'h01;
      end
      else if ((dead_cnt_r == '0) && (on_cnt_r < pps_pkg::CL_ON_CYC))
      begin
         on_cnt_r <= on_cnt_r + 8'h01;
      end
   end

   assign gate_en = osc_run && !tick && (dead_cnt_r == '0) && drive_state(state_r) &&
                    (on_cnt_r <= pps_pkg::CL_ON_CYC) &&
                    ((state_r != pps_pkg::ST_CLIM) || (on_cnt_r != pps_pkg::CL_ON_CYC));

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   // off and disconnected when idle
   always_ff @(posedge clock_i)
   begin
      if (rst_i || !active)
      begin
         drain_out_a_oe_o <= 1'b0;
         drain_out_b_oe_o <= 1'b0;
         drive_level_o <= pps_pkg::LEVEL_ZERO;
      end
      else
      begin
         drain_out_a_oe_o <= gate_en && !div_r;
         drain_out_b_oe_o <= gate_en && div_r;
         drive_level_o <= level_r;
      end
   end

   // switches only ever pull the drain low
   assign drain_out_a_o = 1'b0;
   assign drain_out_b_o = 1'b0;
   assign phase_a_o = osc_run && !div_r;
   assign phase_b_o = osc_run && div_r;

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         status_o <= '{state: pps_pkg::ST_OFF, osc_run: 1'b0, osc_full: 1'b0,
                       drive_level: pps_pkg::LEVEL_ZERO};
      end
      else
      begin
         status_o <= '{state: state_r, osc_run: osc_run, osc_full: osc_full,
                       drive_level: level_r};
      end
   end

endmodule // pps_drive_sequencer

`default_nettype wire

// ==== verification/pps_drive_sequencer_assertions.sv ====
// port assertions for the push-pull drive sequencer
`timescale 1ns/100ps
`default_nettype none

module pps_chk #(
   parameter int unsigned OC_TIMEOUT_CYC = 200,
   parameter int unsigned DEAD_MODE_CYC = 200,
   parameter int unsigned SS_TOTAL_CYC = 512
)
(
   input wire logic clock_i, // clock
   input wire logic rst_i, // reset
   input wire logic enable_i, // enable pin
   input wire logic overcurrent_i, // overcurrent
   input wire logic supply_start_i, // start level
   input wire logic supply_nominal_i, // near nominal
   input wire logic supply_uv_i, // undervoltage
   input wire logic drain_out_a_o, // drain a
   input wire logic drain_out_a_oe_o, // switch a
   input wire logic drain_out_b_o, // drain b
   input wire logic drain_out_b_oe_o, // switch b
   input wire logic phase_a_o, // phase a
   input wire logic phase_b_o, // phase b
   input wire logic [pps_pkg::LEVEL_W-1:0] drive_level_o, // amplitude
   input wire pps_pkg::pps_status_s status_o // status
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // ----
   // helper counters
   // ----
   logic [7:0] off_cnt_r;
   logic [7:0] on_cnt_r;
   logic [3:0] idle_cnt_r;
   logic any_on;
   logic idle;
   assign any_on = drain_out_a_oe_o | drain_out_b_oe_o;
   assign idle = !enable_i || supply_uv_i || !supply_start_i;
   always_ff @(posedge clock_i)
   begin
      off_cnt_r <= (rst_i || any_on) ? 8'h00 : off_cnt_r + 8'(off_cnt_r != 8'hFF);
      on_cnt_r <= (rst_i || !any_on) ? 8'h00 : on_cnt_r + 8'(on_cnt_r != 8'hFF);
      // pin filter and state need about five edges to act
      idle_cnt_r <= (rst_i || !idle) ? 4'h0 : idle_cnt_r + 4'(idle_cnt_r != 4'hF);
   end
   // ----
   // assertions
   // ----
   a_no_overlap: assert property (!(drain_out_a_oe_o && drain_out_b_oe_o))
      else $error("both switches on");
   a_dead_gap: assert property (($rose(drain_out_a_oe_o) || $rose(drain_out_b_oe_o))
      |-> off_cnt_r >= pps_pkg::DEAD_CYC)
      else $error("dead gap too short");
   a_phase_compl: assert property (!(phase_a_o && phase_b_o))
      else $error("phases overlap");
   a_idle_off: assert property (idle_cnt_r >= 4'h7 |-> !any_on && drive_level_o == 8'h00)
      else $error("drive while inactive");
   a_dead_off: assert property (status_o.state == pps_pkg::ST_DEAD [*2] |-> !any_on)
      else $error("drive in dead-time mode");
   a_clim_width: assert property (status_o.state == pps_pkg::ST_CLIM [*4]
      |-> on_cnt_r <= pps_pkg::CL_ON_CYC)
      else $error("limit pulse too long");
   a_level_ramp: assert property ($past(drive_level_o) != 8'h00 && drive_level_o != 8'h00
      |-> 8'(drive_level_o - $past(drive_level_o)) <= 8'h01)
      else $error("level not ramping");
   a_dead_exit: assert property ($past(status_o.state) == pps_pkg::ST_DEAD
      && status_o.state != pps_pkg::ST_DEAD |-> status_o.state != pps_pkg::ST_RUN)
      else $error("dead exit skips soft-start");
   a_soft_first: assert property ($past(status_o.state) == pps_pkg::ST_OFF
      && status_o.state != pps_pkg::ST_OFF |-> status_o.state == pps_pkg::ST_SOFT)
      else $error("start not via soft-start");
endmodule // pps_chk

bind pps_drive_sequencer pps_chk #(.OC_TIMEOUT_CYC(OC_TIMEOUT_CYC),
   .DEAD_MODE_CYC(DEAD_MODE_CYC), .SS_TOTAL_CYC(SS_TOTAL_CYC)) u_pps_chk (
   .clock_i(clock_i), .rst_i(rst_i), .enable_i(enable_i), .overcurrent_i(overcurrent_i),
   .supply_start_i(supply_start_i), .supply_nominal_i(supply_nominal_i),
   .supply_uv_i(supply_uv_i), .drain_out_a_o(drain_out_a_o),
   .drain_out_a_oe_o(drain_out_a_oe_o), .drain_out_b_o(drain_out_b_o),
   .drain_out_b_oe_o(drain_out_b_oe_o), .phase_a_o(phase_a_o), .phase_b_o(phase_b_o),
   .drive_level_o(drive_level_o), .status_o(status_o));

`default_nettype wire

// ==== verification/pps_primary_model.sv ====
// transformer primary behind the two switches, with on-time tallies
`timescale 1ns/100ps
`default_nettype none

module pps_primary_model
(
   input wire logic clock_i, // clock
   input wire logic sw_a_i, // switch a on
   input wire logic sw_b_i, // switch b on
   input wire logic fault_i, // shorted secondary
   input wire logic clear_i, // restart tallies
   output logic overcurrent_o, // current above threshold
   output var int on_a_o, // on cycles of a
   output var int on_b_o, // on cycles of b
   output var int min_len_o, // shortest pulse
   output var int max_len_o // longest pulse
);
   int len_r;
   // a short stays sensed across dead gaps, so the level is held
   assign overcurrent_o = fault_i;
   always_ff @(posedge clock_i)
   begin
      if (clear_i)
      begin
         on_a_o <= 0;
         on_b_o <= 0;
         len_r <= 0;
         min_len_o <= 9999;
         max_len_o <= 0;
      end
      else
      begin
         on_a_o <= on_a_o + int'(sw_a_i);
         on_b_o <= on_b_o + int'(sw_b_i);
         len_r <= (sw_a_i || sw_b_i) ? len_r + 1 : 0;
         if (!sw_a_i && !sw_b_i && len_r != 0)
         begin
            min_len_o <= (len_r < min_len_o) ? len_r : min_len_o;
            max_len_o <= (len_r > max_len_o) ? len_r : max_len_o;
         end
      end
   end
endmodule // pps_primary_model

`default_nettype wire

// ==== verification/pps_drive_sequencer_tb.sv ====
// self-checking bench for the push-pull drive sequencer
`timescale 1ns/100ps
`default_nettype none

module pps_drive_sequencer_tb;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic enable = 1'b0;
   logic start = 1'b0;
   logic nominal = 1'b0;
   logic uv = 1'b0;
   logic fault = 1'b0;
   logic clear = 1'b1;
   logic oc, d_a, d_b, oe_a, oe_b, ph_a, ph_b;
   logic [pps_pkg::LEVEL_W-1:0] level;
   pps_pkg::pps_status_s status;
   int on_a, on_b, min_len, max_len, n, cycles;
   int bad_count = 0;
   int num_checks = 0;

   pps_drive_sequencer #(.OC_TIMEOUT_CYC(200), .DEAD_MODE_CYC(200), .SS_TOTAL_CYC(512))
      u_pps_drive_sequencer (.clock_i(clock_i), .rst_i(rst_i), .enable_i(enable),
      .overcurrent_i(oc), .supply_start_i(start), .supply_nominal_i(nominal),
      .supply_uv_i(uv), .drain_out_a_o(d_a), .drain_out_a_oe_o(oe_a), .drain_out_b_o(d_b),
      .drain_out_b_oe_o(oe_b), .phase_a_o(ph_a), .phase_b_o(ph_b), .drive_level_o(level),
      .status_o(status));
   pps_primary_model u_pps_primary_model (.clock_i(clock_i), .sw_a_i(oe_a), .sw_b_i(oe_b),
      .fault_i(fault), .clear_i(clear), .overcurrent_o(oc), .on_a_o(on_a), .on_b_o(on_b),
      .min_len_o(min_len), .max_len_o(max_len));

   initial
   begin
      forever #4 clock_i = ~clock_i;
   end
   // ----
   // shared tasks
   // ----
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wait_st(input pps_pkg::pps_state_e s, input int lim);
      n = 0;
      while (status.state !== s && n < lim)
      begin
         @(posedge clock_i);
         #1;
         n++;
      end
      check("state", 16'(status.state), 16'(s));
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge clock_i);
      #1;
   endtask
   task automatic results();
      if (bad_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_power_up();
      @(posedge clock_i) enable <= 1'b1;
      idle(50);
      check("osc_run", 16'(status.osc_run), 16'h0000);
      @(posedge clock_i) start <= 1'b1;
      wait_st(pps_pkg::ST_SOFT, 10);
      wait_st(pps_pkg::ST_RUN, 700);
      check("level", 16'(level), 16'h00FF);
      check("st_level", 16'(status.drive_level), 16'h00FF);
      @(posedge clock_i) clear <= 1'b0;
      idle(2000);
      check("startup_len", 16'(max_len >= 180), 16'h0001);
      @(posedge clock_i) nominal <= 1'b1;
      // filter delay plus two start-up halves before the tallies restart
      idle(450);
      check("osc_full", 16'(status.osc_full), 16'h0001);
      check("phase_compl", 16'(ph_a ^ ph_b), 16'h0001);
      @(posedge clock_i) clear <= 1'b1;
      @(posedge clock_i) clear <= 1'b0;
      idle(4000);
      check("nominal_len", 16'(max_len <= 160), 16'h0001);
      check("spread", 16'(max_len != min_len), 16'h0001);
      check("both_on", 16'(on_a > 1000 && on_b > 1000), 16'h0001);
      check("balance", 16'((on_a - on_b) <= 160 && (on_b - on_a) <= 160), 16'h0001);
   endtask
   task automatic t_limit();
      @(posedge clock_i) fault <= 1'b1;
      wait_st(pps_pkg::ST_CLIM, 20);
      @(posedge clock_i) clear <= 1'b1;
      @(posedge clock_i) clear <= 1'b0;
      // longer than one half period, short of the 200-cycle timeout
      idle(170);
      check("limit_len", 16'(max_len <= 71 && max_len > 0), 16'h0001);
      @(posedge clock_i) fault <= 1'b0;
      wait_st(pps_pkg::ST_RUN, 10);
   endtask
   task automatic t_timeout();
      @(posedge clock_i) fault <= 1'b1;
      wait_st(pps_pkg::ST_CLIM, 20);
      idle(150);
      @(posedge clock_i) fault <= 1'b0;
      wait_st(pps_pkg::ST_RUN, 10);
      @(posedge clock_i) fault <= 1'b1;
      wait_st(pps_pkg::ST_CLIM, 20);
      wait_st(pps_pkg::ST_DEAD, 300);
      check("clim_time", 16'(n >= 197 && n <= 202), 16'h0001);
      @(posedge clock_i) fault <= 1'b0;
      wait_st(pps_pkg::ST_SOFT, 300);
      check("dead_time", 16'(n >= 196 && n <= 202), 16'h0001);
      wait_st(pps_pkg::ST_RUN, 700);
   endtask
   task automatic t_disable();
      @(posedge clock_i) enable <= 1'b0;
      wait_st(pps_pkg::ST_OFF, 10);
      idle(3);
      check("oe_off", 16'({oe_a, oe_b}), 16'h0000);
      check("level_off", 16'(level), 16'h0000);
      check("drain_low", 16'({d_a, d_b}), 16'h0000);
      @(posedge clock_i) enable <= 1'b1;
      wait_st(pps_pkg::ST_SOFT, 10);
      wait_st(pps_pkg::ST_RUN, 700);
      @(posedge clock_i) uv <= 1'b1;
      wait_st(pps_pkg::ST_OFF, 10);
      idle(3);
      check("oe_uv", 16'({oe_a, oe_b}), 16'h0000);
      @(posedge clock_i) uv <= 1'b0;
      wait_st(pps_pkg::ST_SOFT, 10);
   endtask

   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         bad_count++;
         results();
      end
   end

   initial
   begin
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      t_power_up();
      t_limit();
      t_timeout();
      t_disable();
      results();
   end
endmodule // pps_drive_sequencer_tb

`default_nettype wire
